// ---- logic/cam_defs.vh ----
// Constants of the 4-bit core: bus offsets, opcodes, field positions, reset values, timing.
// Assumes a 20 MHz system clock and byte addresses on a 32-bit AHB-Lite register bus.
//
// What this block does
// - Indirect RAM address is page, middle and low registers joined into 10 bits.
// - Direct RAM instructions take two words; the second is the 10-bit address.
// - Sixteen memory registers at RAM $040-$04F, used by load and swap ops.
// - Long jump, long branch and long call reach the whole program space.
// - Page branch swaps only the low 8 counter bits, keeping the page.
// - Zero-page call lands only in program addresses $0000-$003F.
// - Table branch target built from 4-bit immediate, accumulator and aux register.
// - Six register-to-register moves: four into the accumulator, two swaps.
// - Arithmetic on accumulator, aux register or RAM nibble.
// - Compares of accumulator or RAM against a constant set the branch flag.
// - Six RAM bit ops: set, clear, test, indirect and direct.
// - Input/output ops drive and read the general port.
// - Control ops enter the low-power modes.
// - Standby holds CPU and port state; RAM kept; wake on unmasked request.
// - Stop resets program counter, branch flag, interrupt and port state; RAM and data registers kept.
// - Leaving stop waits the oscillator settle time before running.
// - Stop or sleep with interrupts off and an unmasked request acts as no-op.
// - In stop every port pin is released to high impedance.
// - Reset clears interrupt enable and requests, sets all masks.
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH

// Register byte offsets
`define CAM_OFS_ACC     8'h00
`define CAM_OFS_AUX     8'h04
`define CAM_OFS_PAGE    8'h08
`define CAM_OFS_MID     8'h0C
`define CAM_OFS_LOW     8'h10
`define CAM_OFS_SWP1    8'h14
`define CAM_OFS_SWP2    8'h18
`define CAM_OFS_FLAGS   8'h1C
`define CAM_OFS_PC      8'h20
`define CAM_OFS_INSTR   8'h24
`define CAM_OFS_STATUS  8'h28
`define CAM_OFS_IRQ     8'h2C

// Field positions of the interrupt register
`define CAM_IRQ_GIE_BIT 8
`define CAM_IRQ_MSK_LSB 4

// Reset values
`define CAM_RST_PC      14'h0000
`define CAM_RST_BCF     1'b1
`define CAM_RST_MSK     4'hF
`define CAM_MEMREG_PAGE 6'h04
`define CAM_ZPAGE_HI    8'h00

// Timing
`define CAM_CLK_MHZ        20
`define CAM_OSC_SETTLE_US  1000
`define CAM_SETTLE_CYC     (`CAM_OSC_SETTLE_US * `CAM_CLK_MHZ)

// Opcodes
`define CAM_OP_LDIA   8'h01
`define CAM_OP_LDIB   8'h02
`define CAM_OP_LDIW   8'h03
`define CAM_OP_LDIX   8'h04
`define CAM_OP_LDIY   8'h05
`define CAM_OP_LAB    8'h10
`define CAM_OP_LAY    8'h11
`define CAM_OP_LASP1  8'h12
`define CAM_OP_LASP2  8'h13
`define CAM_OP_LDMREG 8'h14
`define CAM_OP_XMREG  8'h15
`define CAM_OP_XSP1   8'h16
`define CAM_OP_XSP2   8'h17
`define CAM_OP_LAMI   8'h20
`define CAM_OP_LAMD   8'h21
`define CAM_OP_SAMI   8'h22
`define CAM_OP_SAMD   8'h23
`define CAM_OP_ADDM   8'h30
`define CAM_OP_ADDI   8'h31
`define CAM_OP_ADCM   8'h32
`define CAM_OP_SUBM   8'h33
`define CAM_OP_INCA   8'h34
`define CAM_OP_DECA   8'h35
`define CAM_OP_INCB   8'h36
`define CAM_OP_DECB   8'h37
`define CAM_OP_ANDM   8'h38
`define CAM_OP_ORM    8'h39
`define CAM_OP_XORM   8'h3A
`define CAM_OP_SEC    8'h3B
`define CAM_OP_REC    8'h3C
`define CAM_OP_CEQAI  8'h40
`define CAM_OP_CEQMI  8'h41
`define CAM_OP_CLTAI  8'h42
`define CAM_OP_CLTMI  8'h43
`define CAM_OP_BSETI  8'h50
`define CAM_OP_BCLRI  8'h51
`define CAM_OP_BTSTI  8'h52
`define CAM_OP_BSETD  8'h53
`define CAM_OP_BCLRD  8'h54
`define CAM_OP_BTSTD  8'h55
`define CAM_OP_JUMPL  8'h60
`define CAM_OP_BRLONG 8'h61
`define CAM_OP_CALLL  8'h62
`define CAM_OP_CALZ   8'h63
`define CAM_OP_BRP    8'h64
`define CAM_OP_BRTAB  8'h65
`define CAM_OP_SETD   8'h70
`define CAM_OP_CLRD   8'h71
`define CAM_OP_LAPORT 8'h72
`define CAM_OP_LPORTA 8'h73
`define CAM_OP_STOP   8'h7C
`define CAM_OP_SLEEP  8'h7D

`endif

// ---- logic/cam_ram.v ----
// Data RAM of the core, memory registers included; read data registered.
// Assumes one port: write and read share the address, no reset (contents kept).
`timescale 1ns/100ps
`default_nettype none

module cam_ram #(
    parameter AW = 10,
    parameter DW = 4
) (
    // Clock
    input  wire          ref_clk,
    // Access port
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata_q
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end

endmodule // cam_ram

`default_nettype wire

// ---- logic/cam_core.v ----
// Program-visible state of the 4-bit core, its instruction executor and power modes.
// Assumes an AHB-Lite master with single word transfers and synchronous pins.
`timescale 1ns/100ps
`default_nettype none
`include "cam_defs.vh"

module cam_core #(
    parameter        ADDR_W     = 8,
    parameter        IO_W       = 9,
    parameter [23:0] SETTLE_CYC = `CAM_SETTLE_CYC
) (
    // Clock and reset
    input  wire              ref_clk,
    input  wire              rst_b,
    // AHB-Lite slave
    input  wire              hsel,
    input  wire [ADDR_W-1:0] haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire              hready,
    input  wire [31:0]       hwdata,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    // Interrupt requests and stop wake-up
    input  wire [3:0]        irq_req,
    input  wire              stop_wake,
    // General port
    input  wire [IO_W-1:0]   port_in,
    output reg  [IO_W-1:0]   port_out,
    output reg  [IO_W-1:0]   port_oe,
    // Oscillator running
    output reg               osc_run
);

    localparam [5:0] ST_RUN    = 6'h01;
    localparam [5:0] ST_DEC    = 6'h02;
    localparam [5:0] ST_MEM    = 6'h04;
    localparam [5:0] ST_DOZE   = 6'h08;
    localparam [5:0] ST_STOP   = 6'h10;
    localparam [5:0] ST_SETTLE = 6'h20;

    reg [5:0]        state_q;
    reg [3:0]        acc_q, aux_q, mid_q, low_q, swp1_q, swp2_q;
    reg [1:0]        page_q;
    reg              carry_q, bcf_q, gie_q;
    reg [3:0]        if_q, msk_q;
    reg [13:0]       pc_q;
    reg [31:0]       ir_q;
    reg [23:0]       cnt_q;
    reg [ADDR_W-1:0] dph_addr_q;
    reg              dph_wr_q, rd_q;
    reg [31:0]       rd_mux;

    wire [7:0] op       = ir_q[7:0];
    wire [3:0] imm      = ir_q[11:8];
    wire [9:0] dir_addr = ir_q[17:8];
    wire       pend     = |(if_q & ~msk_q);
    wire       addr_ph  = hsel & htrans[1] & hready;
    wire       wr_en    = dph_wr_q;

    // RAM address by addressing mode
    reg        is_direct, is_memreg;
    reg [9:0]  ram_addr;
    always @* begin
        is_direct = (op == `CAM_OP_LAMD) || (op == `CAM_OP_SAMD) || (op == `CAM_OP_BSETD) ||
                    (op == `CAM_OP_BCLRD) || (op == `CAM_OP_BTSTD);
        is_memreg = (op == `CAM_OP_LDMREG) || (op == `CAM_OP_XMREG);
        if (is_memreg) begin
            ram_addr = {`CAM_MEMREG_PAGE, imm};
        end else if (is_direct) begin
            ram_addr = dir_addr;
        end else begin
            ram_addr = {page_q, mid_q, low_q};
        end
    end

    wire [3:0] ram_rd;
    wire [1:0] bit_sel = is_direct ? ir_q[19:18] : ir_q[9:8];
    wire [3:0] bit_msk = 4'h1 << bit_sel;

    reg        ram_we;
    reg [3:0]  ram_wd;
    always @* begin
        ram_we = 1'b0;
        ram_wd = acc_q;
        if (state_q == ST_MEM) begin
            case (op)
                `CAM_OP_SAMI, `CAM_OP_SAMD, `CAM_OP_XMREG: begin
                    ram_we = 1'b1;
                end
                `CAM_OP_BSETI, `CAM_OP_BSETD: begin
                    ram_we = 1'b1;
                    ram_wd = ram_rd | bit_msk;
                end
                `CAM_OP_BCLRI, `CAM_OP_BCLRD: begin
                    ram_we = 1'b1;
                    ram_wd = ram_rd & ~bit_msk;
                end
                default: begin
                    ram_we = 1'b0;
                end
            endcase
        end
    end

    cam_ram #(
        .AW (10),
        .DW (4)
    ) u_ram (
        .ref_clk (ref_clk),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (ram_wd),
        .rdata_q (ram_rd)
    );

    // Adders of the arithmetic ops and the program counter step
    wire [4:0] add_m  = {1'b0, acc_q} + {1'b0, ram_rd};
    wire [4:0] adc_m  = add_m + {4'h0, carry_q};
    wire [4:0] add_i  = {1'b0, acc_q} + {1'b0, imm};
    wire [4:0] sub_m  = {1'b0, acc_q} - {1'b0, ram_rd};
    wire [3:0] inc_a  = acc_q + 4'h1;
    wire [3:0] dec_a  = acc_q - 4'h1;
    wire [3:0] inc_b  = aux_q + 4'h1;
    wire [3:0] dec_b  = aux_q - 4'h1;
    wire [1:0] op_len = is_direct ? 2'd2 : 2'd1;
    wire [13:0] pc_nx = pc_q + {12'h000, op_len};

    // Register read mux
    always @* begin
        rd_mux = 32'h0000_0000;
        case (dph_addr_q)
            `CAM_OFS_ACC:    rd_mux[3:0]  = acc_q;
            `CAM_OFS_AUX:    rd_mux[3:0]  = aux_q;
            `CAM_OFS_PAGE:   rd_mux[1:0]  = page_q;
            `CAM_OFS_MID:    rd_mux[3:0]  = mid_q;
            `CAM_OFS_LOW:    rd_mux[3:0]  = low_q;
            `CAM_OFS_SWP1:   rd_mux[3:0]  = swp1_q;
            `CAM_OFS_SWP2:   rd_mux[3:0]  = swp2_q;
            `CAM_OFS_FLAGS:  rd_mux[1:0]  = {bcf_q, carry_q};
            `CAM_OFS_PC:     rd_mux[13:0] = pc_q;
            `CAM_OFS_INSTR:  rd_mux       = ir_q;
            `CAM_OFS_STATUS: rd_mux[6:0]  = {state_q != ST_RUN, state_q};
            `CAM_OFS_IRQ:    rd_mux[8:0]  = {gie_q, msk_q, if_q};
            default:         rd_mux       = 32'h0000_0000;
        endcase
    end

    // Bus slave: writes with no wait, reads with one wait state
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            dph_addr_q <= {ADDR_W{1'b0}};
            dph_wr_q   <= 1'b0;
            rd_q       <= 1'b0;
        end else begin
            hresp    <= 1'b0;
            dph_wr_q <= addr_ph & hwrite;
            if (addr_ph) begin
                dph_addr_q <= haddr;
            end
            if (addr_ph && !hwrite) begin
                hreadyout <= 1'b0;
                rd_q      <= 1'b1;
            end else if (rd_q) begin
                hrdata    <= rd_mux;
                hreadyout <= 1'b1;
                rd_q      <= 1'b0;
            end
        end
    end

    // Core state, modes and software writes
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q  <= ST_RUN;
            acc_q    <= 4'h0;
            aux_q    <= 4'h0;
            page_q   <= 2'h0;
            mid_q    <= 4'h0;
            low_q    <= 4'h0;
            swp1_q   <= 4'h0;
            swp2_q   <= 4'h0;
            carry_q  <= 1'b0;
            bcf_q    <= `CAM_RST_BCF;
            pc_q     <= `CAM_RST_PC;
            gie_q    <= 1'b0;
            if_q     <= 4'h0;
            msk_q    <= `CAM_RST_MSK;
            ir_q     <= 32'h0000_0000;
            cnt_q    <= 24'h00_0000;
            port_out <= {IO_W{1'b0}};
            port_oe  <= {IO_W{1'b0}};
            osc_run  <= 1'b1;
        end else begin
            // Requests: clear by writing one, a new request wins
            if (state_q != ST_STOP && state_q != ST_SETTLE) begin
                if (wr_en && dph_addr_q == `CAM_OFS_IRQ) begin
                    gie_q <= hwdata[`CAM_IRQ_GIE_BIT];
                    msk_q <= hwdata[`CAM_IRQ_MSK_LSB+3:`CAM_IRQ_MSK_LSB];
                    if_q <= (if_q & ~hwdata[3:0]) | irq_req;
                end else begin
                    if_q <= if_q | irq_req;
                end
            end
            case (state_q)
                ST_RUN: begin
                    if (wr_en) begin
                        case (dph_addr_q)
                            `CAM_OFS_ACC:   acc_q   <= hwdata[3:0];
                            `CAM_OFS_AUX:   aux_q   <= hwdata[3:0];
                            `CAM_OFS_PAGE:  page_q  <= hwdata[1:0];
                            `CAM_OFS_MID:   mid_q   <= hwdata[3:0];
                            `CAM_OFS_LOW:   low_q   <= hwdata[3:0];
                            `CAM_OFS_SWP1:  swp1_q  <= hwdata[3:0];
                            `CAM_OFS_SWP2:  swp2_q  <= hwdata[3:0];
                            `CAM_OFS_FLAGS: carry_q <= hwdata[0];
                            `CAM_OFS_INSTR: begin
                                ir_q    <= hwdata;
                                state_q <= ST_DEC;
                            end
                            default: begin
                                state_q <= ST_RUN;
                            end
                        endcase
                    end
                end
                ST_DEC: begin
                    state_q <= ST_RUN;
                    pc_q    <= pc_nx;
                    case (op)
                        `CAM_OP_LDIA:   acc_q  <= imm;
                        `CAM_OP_LDIB:   aux_q  <= imm;
                        `CAM_OP_LDIW:   page_q <= imm[1:0];
                        `CAM_OP_LDIX:   mid_q  <= imm;
                        `CAM_OP_LDIY:   low_q  <= imm;
                        `CAM_OP_LAB:    acc_q  <= aux_q;
                        `CAM_OP_LAY:    acc_q  <= low_q;
                        `CAM_OP_LASP1:  acc_q  <= swp1_q;
                        `CAM_OP_LASP2:  acc_q  <= swp2_q;
                        `CAM_OP_XSP1: begin
                            mid_q  <= swp1_q;
                            swp1_q <= mid_q;
                        end
                        `CAM_OP_XSP2: begin
                            low_q  <= swp2_q;
                            swp2_q <= low_q;
                        end
                        `CAM_OP_ADDI: begin
                            acc_q <= add_i[3:0];
                            bcf_q <= add_i[4];
                        end
                        `CAM_OP_INCA: begin
                            acc_q <= inc_a;
                            bcf_q <= |inc_a;
                        end
                        `CAM_OP_DECA: begin
                            acc_q <= dec_a;
                            bcf_q <= ~&dec_a;
                        end
                        `CAM_OP_INCB: begin
                            aux_q <= inc_b;
                            bcf_q <= |inc_b;
                        end
                        `CAM_OP_DECB: begin
                            aux_q <= dec_b;
                            bcf_q <= ~&dec_b;
                        end
                        `CAM_OP_SEC:    carry_q <= 1'b1;
                        `CAM_OP_REC:    carry_q <= 1'b0;
                        `CAM_OP_CEQAI:  bcf_q   <= (acc_q != imm);
                        `CAM_OP_CLTAI:  bcf_q   <= (imm > acc_q);
                        `CAM_OP_JUMPL: begin
                            pc_q  <= ir_q[21:8];
                            bcf_q <= 1'b1;
                        end
                        `CAM_OP_BRLONG, `CAM_OP_BRP: begin
                            if (bcf_q) begin
                                if (op == `CAM_OP_BRLONG) begin
                                    pc_q <= ir_q[21:8];
                                end else begin
                                    pc_q <= {pc_q[13:8], ir_q[15:8]};
                                end
                            end
                            bcf_q <= 1'b1;
                        end
                        `CAM_OP_CALLL:  pc_q <= ir_q[21:8];
                        `CAM_OP_CALZ:   pc_q <= {`CAM_ZPAGE_HI, ir_q[13:8]};
                        `CAM_OP_BRTAB:  pc_q <= {2'b00, imm, acc_q, aux_q};
                        `CAM_OP_SETD: begin
                            port_out[imm] <= 1'b1;
                            port_oe[imm]  <= 1'b1;
                        end
                        `CAM_OP_CLRD: begin
                            port_out[imm] <= 1'b0;
                            port_oe[imm]  <= 1'b1;
                        end
                        `CAM_OP_LAPORT: acc_q <= port_in[3:0];
                        `CAM_OP_LPORTA: begin
                            port_out[3:0] <= acc_q;
                            port_oe[3:0]  <= 4'hF;
                        end
                        `CAM_OP_STOP: begin
                            if (gie_q || !pend) begin
                                state_q  <= ST_STOP;
                                osc_run  <= 1'b0;
                                pc_q     <= `CAM_RST_PC;
                                bcf_q    <= `CAM_RST_BCF;
                                gie_q    <= 1'b0;
                                if_q     <= 4'h0;
                                msk_q    <= `CAM_RST_MSK;
                                port_out <= {IO_W{1'b0}};
                                port_oe  <= {IO_W{1'b0}};
                            end
                        end
                        `CAM_OP_SLEEP: begin
                            if (gie_q || !pend) begin
                                state_q <= ST_DOZE;
                            end
                        end
                        `CAM_OP_LDMREG, `CAM_OP_XMREG, `CAM_OP_LAMI, `CAM_OP_LAMD, `CAM_OP_SAMI,
                        `CAM_OP_SAMD, `CAM_OP_ADDM, `CAM_OP_ADCM, `CAM_OP_SUBM, `CAM_OP_ANDM,
                        `CAM_OP_ORM, `CAM_OP_XORM, `CAM_OP_CEQMI, `CAM_OP_CLTMI, `CAM_OP_BSETI,
                        `CAM_OP_BCLRI, `CAM_OP_BTSTI, `CAM_OP_BSETD, `CAM_OP_BCLRD, `CAM_OP_BTSTD: begin
                            state_q <= ST_MEM;
                        end
                        default: begin
                            state_q <= ST_RUN;
                        end
                    endcase
                end
                ST_MEM: begin
                    state_q <= ST_RUN;
                    case (op)
                        `CAM_OP_LDMREG, `CAM_OP_XMREG, `CAM_OP_LAMI, `CAM_OP_LAMD: begin
                            acc_q <= ram_rd;
                        end
                        `CAM_OP_ADDM: begin
                            acc_q <= add_m[3:0];
                            bcf_q <= add_m[4];
                        end
                        `CAM_OP_ADCM: begin
                            acc_q   <= adc_m[3:0];
                            carry_q <= adc_m[4];
                            bcf_q   <= adc_m[4];
                        end
                        `CAM_OP_SUBM: begin
                            acc_q <= sub_m[3:0];
                            bcf_q <= ~sub_m[4];
                        end
                        `CAM_OP_ANDM:   acc_q <= acc_q & ram_rd;
                        `CAM_OP_ORM:    acc_q <= acc_q | ram_rd;
                        `CAM_OP_XORM:   acc_q <= acc_q ^ ram_rd;
                        `CAM_OP_CEQMI:  bcf_q <= (ram_rd != imm);
                        `CAM_OP_CLTMI:  bcf_q <= (imm > ram_rd);
                        `CAM_OP_BTSTI, `CAM_OP_BTSTD: begin
                            bcf_q <= |(ram_rd & bit_msk);
                        end
                        default: begin
                            state_q <= ST_RUN;
                        end
                    endcase
                end
                ST_DOZE: begin
                    if (pend) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (stop_wake) begin
                        state_q <= ST_SETTLE;
                        osc_run <= 1'b1;
                        cnt_q   <= 24'h00_0000;
                    end
                end
                ST_SETTLE: begin
                    cnt_q <= cnt_q + 24'h00_0001;
                    if (cnt_q >= SETTLE_CYC - 24'h00_0001) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

endmodule // cam_core

`default_nettype wire

// ---- verification/cam_core_monitor.sv ----
// Checker for cam_core: bus wait states, stop-mode pins, wake-up, reset state.
// Bound to cam_core from the bench; watches its ports only.
`timescale 1ns/100ps
`default_nettype none

module cam_core_monitor #(
    parameter IO_W = 9
) (
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            rst_b,
    // Bus
    input wire logic            hsel,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic            hresp,
    // Power and port
    input wire logic            stop_wake,
    input wire logic            osc_run,
    input wire logic [IO_W-1:0] port_out,
    input wire logic [IO_W-1:0] port_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire req = hsel && htrans[1] && hready;

    sequence one_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence

    rd_wait_a: assert property (req && !hwrite |=> one_wait_s) else $error("read wait state wrong");
    wr_nowait_a: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
    wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
    resp_okay_a: assert property (!hresp) else $error("error response given");
    stop_hiz_a: assert property (!osc_run |-> port_oe == '0) else $error("pin driven in stop");
    stop_clear_a: assert property ($fell(osc_run) |-> port_out == '0) else $error("port kept in stop");
    stop_hold_a: assert property (!osc_run && !stop_wake |=> !osc_run) else $error("stop left alone");
    wake_osc_a: assert property (!osc_run && stop_wake |=> osc_run) else $error("oscillator not restarted");
    reset_pins_a: assert property ($rose(rst_b) |-> osc_run && port_oe == '0) else $error("reset pins wrong");
endmodule // cam_core_monitor

`default_nettype wire

// ---- verification/cpu_addressing_power_modes_tb.sv ----
// Self-checking bench for cam_core over AHB-Lite.
// Assumes cam_defs.vh on the include path; settle count shortened to 8.
`timescale 1ns/100ps
`default_nettype none
`include "cam_defs.vh"

module cpu_addressing_power_modes_tb;
    logic        ref_clk, rst_b, hsel, hwrite, stop_wake;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, rdv;
    logic [3:0]  irq_req;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, osc_run;
    wire  [8:0]  port_out, port_oe;
    int          errors, num_checks;

    cam_core #(.SETTLE_CYC(24'd8)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .stop_wake(stop_wake),
        .port_in(port_out), .port_out(port_out), .port_oe(port_oe), .osc_run(osc_run));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            tally_and_finish;
        end
    endtask

    // One single transfer; read data lands in rdv
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= adr; hwrite <= wr;
        rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= dat;
        rdy;
        rdv = hrdata;
    endtask

    // Run one instruction, then poll until not busy or in a wait mode
    task automatic exec(input logic [31:0] word);
        int n;
        bus(1, `CAM_OFS_INSTR, word);
        n = 0;
        do begin
            bus(0, `CAM_OFS_STATUS, 0);
            n++;
        end while (rdv[2:1] !== 2'h0 && n < 20);
        if (n >= 20) chk("not busy", 0, rdv);
    endtask

    task automatic pulse_irq;
        irq_req <= 4'h1;
        @(posedge ref_clk);
        irq_req <= 4'h0;
    endtask

    task automatic s_reset;
        bus(0, `CAM_OFS_FLAGS, 0); chk("flags", 32'h2, rdv);
        bus(0, `CAM_OFS_IRQ, 0); chk("irq reg", 32'hF0, rdv);
        bus(0, 8'h30, 0); chk("unmapped", 0, rdv);
        bus(1, `CAM_OFS_PC, 32'h55); bus(0, `CAM_OFS_PC, 0); chk("pc", 0, rdv);
    endtask

    task automatic s_ram;
        bus(1, `CAM_OFS_PAGE, 2); bus(1, `CAM_OFS_MID, 5); bus(1, `CAM_OFS_LOW, 'hA);
        bus(1, `CAM_OFS_ACC, 7); exec(`CAM_OP_SAMI); bus(1, `CAM_OFS_ACC, 0);
        exec({10'h25A, `CAM_OP_LAMD}); bus(0, `CAM_OFS_ACC, 0); chk("acc", 7, rdv);
        bus(0, `CAM_OFS_PC, 0); chk("pc", 3, rdv);
        bus(1, `CAM_OFS_ACC, 9); exec({10'h043, `CAM_OP_SAMD}); bus(1, `CAM_OFS_ACC, 0);
        exec({4'h3, `CAM_OP_LDMREG}); bus(0, `CAM_OFS_ACC, 0); chk("memreg", 9, rdv);
        exec({4'h1, `CAM_OP_ADDI}); bus(0, `CAM_OFS_ACC, 0); chk("acc", 'hA, rdv);
        bus(0, `CAM_OFS_FLAGS, 0); chk("flags", 0, rdv);
    endtask

    task automatic s_branch;
        exec({14'h3ABC, `CAM_OP_JUMPL}); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h3ABC, rdv);
        exec({8'h12, `CAM_OP_BRP}); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h3A12, rdv);
        bus(1, `CAM_OFS_ACC, 5); bus(1, `CAM_OFS_AUX, 6);
        exec({4'h1, `CAM_OP_BRTAB}); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h0156, rdv);
        exec({6'h3F, `CAM_OP_CALZ}); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h003F, rdv);
    endtask

    task automatic s_stop;
        int n;
        bus(1, `CAM_OFS_IRQ, 0); pulse_irq;
        exec(`CAM_OP_STOP); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h40, rdv);
        exec(`CAM_OP_SLEEP); bus(0, `CAM_OFS_PC, 0); chk("pc", 'h41, rdv);
        chk("osc", 1, osc_run);
        bus(1, `CAM_OFS_IRQ, 'hF); exec({4'h2, `CAM_OP_SETD});
        chk("port out", 'h004, port_out); chk("port oe", 'h004, port_oe);
        exec(`CAM_OP_LAPORT); bus(0, `CAM_OFS_ACC, 0); chk("port in", 4, rdv);
        exec(`CAM_OP_STOP); chk("osc", 0, osc_run); chk("oe", 0, port_oe);
        stop_wake <= 1'b1; @(posedge ref_clk); stop_wake <= 1'b0;
        bus(0, `CAM_OFS_STATUS, 0); chk("status", 'h60, rdv);
        n = 0;
        do begin
            bus(0, `CAM_OFS_STATUS, 0);
            n++;
        end while (rdv !== 32'h1 && n < 20);
        chk("status", 1, rdv);
        bus(0, `CAM_OFS_PC, 0); chk("pc", 0, rdv);
        bus(0, `CAM_OFS_IRQ, 0); chk("irq reg", 'hF0, rdv);
        exec({10'h25A, `CAM_OP_LAMD}); bus(0, `CAM_OFS_ACC, 0); chk("ram", 7, rdv);
    endtask

    task automatic s_sleep;
        exec(`CAM_OP_SLEEP); bus(0, `CAM_OFS_STATUS, 0); chk("status", 'h48, rdv);
        bus(1, `CAM_OFS_ACC, 3); bus(0, `CAM_OFS_ACC, 0); chk("acc", 7, rdv);
        chk("osc", 1, osc_run);
        bus(1, `CAM_OFS_IRQ, 'hE0); pulse_irq;
        bus(0, `CAM_OFS_STATUS, 0); chk("status", 1, rdv);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        rst_b = 0; hsel = 0; hwrite = 0; stop_wake = 0; haddr = 0; htrans = 0; hwdata = 0; irq_req = 0;
        errors = 0;
        num_checks = 0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        s_reset;
        s_ram;
        s_branch;
        s_stop;
        s_sleep;
        tally_and_finish;
    end
endmodule // cpu_addressing_power_modes_tb

bind cam_core cam_core_monitor #(.IO_W(IO_W)) u_mon (.ref_clk, .rst_b, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .stop_wake, .osc_run, .port_out, .port_oe);

`default_nettype wire
